// [eir_top.sv]
// External interrupt request logic: registers, flags and request outputs
`timescale 1ns/1ns
`default_nettype none
module eir_top
	import eir_pkg::*;
(
	input  wire logic                  clock,            // System clock, 100 MHz
	input  wire logic                  reset_n,          // Synchronous reset, active low
	input  wire logic [EIR_ADDR_W-1:0] addr,             // Register address
	input  wire logic [EIR_DATA_W-1:0] wr_data,          // Write data
	input  wire logic                  wr_en,            // Write strobe
	input  wire logic                  rd_en,            // Read strobe
	output logic      [EIR_DATA_W-1:0] rd_data,          // Read data, cycle after rd_en
	input  wire logic [7:0]            ext_request_pin,  // Request pins, asynchronous
	output logic      [7:0]            request_out,      // Per-input forwarded requests
	output logic                       irq               // Any forwarded request
);

	logic [7:0] sense_high_r, sense_high_nxt;  // sense_control_high
	logic [7:0] sense_low_r,  sense_low_nxt;   // sense_control_low
	logic [7:0] enable_r,     enable_nxt;      // ext_request_enable, also the mask
	logic [7:0] status_r,     status_nxt;      // ext_request_status flags
	logic [7:0] rd_data_r,    rd_data_nxt;     // Registered read answer
	logic [7:0] request_r,    request_nxt;     // Registered per-input requests
	logic       irq_r,        irq_nxt;         // Registered summary interrupt

	logic [15:0] sense_word;                   // Both sense bytes joined
	logic [7:0]  hit;                          // Request conditions this cycle

	// High byte carries inputs 7..4, low byte inputs 3..0, field n at bit 2n
	assign sense_word = {sense_high_r, sense_low_r};

	// One detector per pin
	genvar gi;
	generate
		for (gi = 0; gi < EIR_NUM_INPUTS; gi++) begin : g_pin
			eir_sense_detect u_det (
				.clock   (clock),
				.reset_n (reset_n),
				.pin     (ext_request_pin[gi]),
				.sense   (sense_word[gi*EIR_SENSE_W +: EIR_SENSE_W]),
				.hit     (hit[gi])
			);
		end
	endgenerate

	// Register writes and flag updates
	always_comb begin
		sense_high_nxt = sense_high_r;
		sense_low_nxt  = sense_low_r;
		enable_nxt     = enable_r;
		status_nxt     = status_r;
		if (wr_en) begin
			case (addr)
				EIR_OFS_SENSE_HIGH: sense_high_nxt = wr_data;
				EIR_OFS_SENSE_LOW:  sense_low_nxt  = wr_data;
				EIR_OFS_ENABLE:     enable_nxt     = wr_data;
				// Zero bits clear, one bits leave the flag as it was
				EIR_OFS_STATUS:     status_nxt     = status_r & wr_data;
				default:            status_nxt     = status_r;  // Unmapped write ignored
			endcase
		end
		// A condition in the clearing cycle wins so no event is lost
		status_nxt = status_nxt | hit;
	end

	// Read answer, present only in the cycle after the strobe
	always_comb begin
		rd_data_nxt = EIR_RD_UNMAPPED;
		if (rd_en) begin
			case (addr)
				EIR_OFS_SENSE_HIGH: rd_data_nxt = sense_high_r;
				EIR_OFS_SENSE_LOW:  rd_data_nxt = sense_low_r;
				EIR_OFS_ENABLE:     rd_data_nxt = enable_r;
				EIR_OFS_STATUS:     rd_data_nxt = status_r;
				default:            rd_data_nxt = EIR_RD_UNMAPPED;
			endcase
		end
	end

	// Forward a request only while enabled and flagged
	always_comb begin
		request_nxt = enable_r & status_r;
		irq_nxt     = |(enable_r & status_r);
	end

	// Registers of the block
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sense_high_r <= EIR_RST_SENSE_HIGH;
			sense_low_r  <= EIR_RST_SENSE_LOW;
			enable_r     <= EIR_RST_ENABLE;
			status_r     <= EIR_RST_STATUS;
			rd_data_r    <= EIR_RD_UNMAPPED;
			request_r    <= EIR_RST_REQUEST;
			irq_r        <= EIR_RST_IRQ;
		end else begin
			sense_high_r <= sense_high_nxt;
			sense_low_r  <= sense_low_nxt;
			enable_r     <= enable_nxt;
			status_r     <= status_nxt;
			rd_data_r    <= rd_data_nxt;
			request_r    <= request_nxt;
			irq_r        <= irq_nxt;
		end
	end

	assign rd_data     = rd_data_r;
	assign request_out = request_r;
	assign irq         = irq_r;

endmodule
`default_nettype wire

// [eir_pkg.sv]
// Constants shared by the external interrupt request logic
// What this block does
// - Sense code: 00 low, 01 fall, 10 rise, 11 both
// - Inputs 7..4 sense fields in high byte
// - Inputs 3..0 sense fields in low byte
// - Flags clear on zero write, never set by software
package eir_pkg;

	localparam int unsigned EIR_NUM_INPUTS = 8;             // External request pins
	localparam int unsigned EIR_ADDR_W     = 16;            // Register address width
	localparam int unsigned EIR_DATA_W     = 8;             // Register data width

	// Register offsets, as byte addresses on the register port
	localparam logic [15:0] EIR_OFS_SENSE_HIGH = 16'hfe12;  // sense_control_high
	localparam logic [15:0] EIR_OFS_SENSE_LOW  = 16'hfe13;  // sense_control_low
	localparam logic [15:0] EIR_OFS_ENABLE     = 16'hfe14;  // ext_request_enable
	localparam logic [15:0] EIR_OFS_STATUS     = 16'hfe15;  // ext_request_status

	// Values after reset
	localparam logic [7:0]  EIR_RST_SENSE_HIGH = 8'h00;
	localparam logic [7:0]  EIR_RST_SENSE_LOW  = 8'h00;
	localparam logic [7:0]  EIR_RST_ENABLE     = 8'h00;
	localparam logic [7:0]  EIR_RST_STATUS     = 8'h00;
	localparam logic [7:0]  EIR_RD_UNMAPPED    = 8'h00;     // Answer to an unmapped read
	localparam logic        EIR_RST_PIN_LEVEL  = 1'b1;      // Idle pin level assumed in reset
	localparam logic [7:0]  EIR_RST_REQUEST    = 8'h00;     // No request forwarded in reset
	localparam logic        EIR_RST_IRQ        = 1'b0;      // Summary interrupt quiet in reset

	// Sense field layout: two bits per input, field n at bit 2n of the joined word
	localparam int unsigned EIR_SENSE_W = 2;

	// Sense codes
	typedef enum logic [1:0] {
		EIR_SENSE_LOW  = 2'h0,  // Low level
		EIR_SENSE_FALL = 2'h1,  // Falling edge
		EIR_SENSE_RISE = 2'h2,  // Rising edge
		EIR_SENSE_BOTH = 2'h3   // Either edge
	} eir_sense_e;

endpackage

// [eir_sense_detect.sv]
// One request pin: synchroniser, edge finder and sense decode
`timescale 1ns/1ns
`default_nettype none
module eir_sense_detect
	import eir_pkg::*;
(
	input  wire logic       clock,     // System clock
	input  wire logic       reset_n,   // Synchronous reset, active low
	input  wire logic       pin,       // Raw pin, asynchronous
	input  wire logic [1:0] sense,     // Sense code for this pin
	output logic            hit        // Request condition seen this cycle
);

	logic sync1_r, sync1_nxt;  // First stage, read only by the second
	logic sync2_r, sync2_nxt;  // Second stage, safe to use
	logic prev_r,  prev_nxt;   // Second stage one cycle ago

	// Next values of the synchroniser and history
	always_comb begin
		sync1_nxt = pin;
		sync2_nxt = sync1_r;
		prev_nxt  = sync2_r;
	end

	// Reset to the idle high level so release does not fake a falling edge
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sync1_r <= EIR_RST_PIN_LEVEL;
			sync2_r <= EIR_RST_PIN_LEVEL;
			prev_r  <= EIR_RST_PIN_LEVEL;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r  <= prev_nxt;
		end
	end

	// Decode the sense code against the synchronised level
	always_comb begin
		case (eir_sense_e'(sense))
			EIR_SENSE_LOW:  hit = ~sync2_r;
			EIR_SENSE_FALL: hit = prev_r & ~sync2_r;
			EIR_SENSE_RISE: hit = ~prev_r & sync2_r;
			EIR_SENSE_BOTH: hit = prev_r ^ sync2_r;
			default:        hit = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// [eir_pins_model.sv]
// Model of the eight request pins outside the block
`timescale 1ns/1ns
`default_nettype none
module eir_pins_model (
	input  wire logic       clock,  // System clock
	input  wire logic [7:0] level,  // Level the bench wants
	output logic      [7:0] pin     // Driven pins, idle high
);
	initial pin = 8'hff;
	// Pins move 3 ns after the edge, so they are asynchronous to sampling
	always @(posedge clock) pin <= #3 level;
endmodule
`default_nettype wire

// [eir_top_monitor.sv]
// Assertion checker for the external request block
`timescale 1ns/1ns
`default_nettype none
module eir_top_monitor
	import eir_pkg::*;
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [7:0]  rd_data,
	input wire logic [7:0]  request_out,
	input wire logic        irq
);
	logic [7:0] en_r;  // Mirror of the enable register
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Mirror follows enable writes so the gate can be judged
	always_ff @(posedge clock) begin
		if (!reset_n) en_r <= 8'h00;
		else if (wr_en && addr == EIR_OFS_ENABLE) en_r <= wr_data;
	end
	a_req_masked: assert property ((request_out & ~$past(en_r)) == 8'h00)
		else $error("request on disabled input");
	a_irq_any: assert property (irq == (|request_out))
		else $error("irq differs from requests");
	a_en_quiet: assert property (wr_en && addr == EIR_OFS_ENABLE && wr_data == 8'h00 |-> ##2 !irq)
		else $error("irq after disable");
	a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside slot");
	a_rd_enable: assert property (rd_en && addr == EIR_OFS_ENABLE |=> rd_data == $past(en_r))
		else $error("enable readback");
	cover property (irq);
	cover property (rd_en && addr == EIR_OFS_STATUS);
	cover property (wr_en && addr == EIR_OFS_STATUS && wr_data == 8'h00);
endmodule
bind eir_top eir_top_monitor u_mon (.clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
	.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .request_out(request_out), .irq(irq));
`default_nettype wire

// [eir_top_bench.sv]
// Self-checking bench for the external request block
`timescale 1ns/1ns
`default_nettype none
module eir_top_bench
	import eir_pkg::*;
;
	logic        clock = 0, reset_n = 0, wr_en = 0, rd_en = 0, irq;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wr_data = 8'h00, rd_data, request_out, level = 8'hff, pins;
	int          failures = 0, comparisons = 0;
	always #5 clock = ~clock;
	eir_pins_model PINS (.clock(clock), .level(level), .pin(pins));
	eir_top DUT (.clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .ext_request_pin(pins), .request_out(request_out), .irq(irq));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		if (failures == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One-cycle strobes; the gap after each keeps strobes from merging
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 chk(rd_data, exp);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	initial begin
		#20000;
		failures++;
		close_out();
	end
	// Sense codes per input: 0 low, 1 fall, 2 rise, 3 both; 4 both, 5 rise, 6 fall, 7 low
	initial begin
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) rd(EIR_OFS_SENSE_HIGH + 16'(i), 8'h00);
		wr(EIR_OFS_SENSE_HIGH, 8'h1b);
		wr(EIR_OFS_SENSE_LOW, 8'he4);
		rd(EIR_OFS_SENSE_HIGH, 8'h1b);
		rd(EIR_OFS_SENSE_LOW, 8'he4);
		level <= 8'h00;
		wt(5);
		rd(EIR_OFS_STATUS, 8'hdb);
		chk({7'h00, irq}, 8'h00);
		wr(EIR_OFS_STATUS, 8'hff);
		rd(EIR_OFS_STATUS, 8'hdb);
		wr(EIR_OFS_STATUS, 8'h00);
		wt(2);
		rd(EIR_OFS_STATUS, 8'h81);
		level <= 8'hff;
		wt(5);
		rd(EIR_OFS_STATUS, 8'hbd);
		wr(EIR_OFS_ENABLE, 8'h04);
		wt(2);
		chk(request_out, 8'h04);
		chk({7'h00, irq}, 8'h01);
		wr(EIR_OFS_STATUS, 8'hfb);
		wt(2);
		rd(EIR_OFS_STATUS, 8'hb9);
		chk(request_out, 8'h00);
		wr(EIR_OFS_ENABLE, 8'h00);
		rd(EIR_OFS_ENABLE, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
